// >>> verilog/usb_flags_defs.svh
// Register offsets, field positions, reset values and timing counts of the USB flag block
`ifndef USB_FLAGS_DEFS_SVH
`define USB_FLAGS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_IRQ_MASK 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_CLEAR 8'h08
`define OFS_EP_RESET 8'h0C
`define OFS_EP_CSR_BASE 8'h10
`define OFS_EP_CSR_STEP 8'h04

// ----------------------------------------------------------------
// Sizes and fields
// ----------------------------------------------------------------
`define NUM_EP 6
`define ADDR_W 8
`define CNT_W 11
`define IRQ_W 14
`define EVT_LO 8
`define BIT_SUSPEND 8
`define BIT_RESUME 9
`define BIT_EXT_RESUME 10
`define BIT_FRAME_START 11
`define BIT_BUS_RESET_DONE 12
`define BIT_WAKEUP 13
`define CSR_TX_COMPLETE 0
`define CSR_BANK0 1
`define CSR_SETUP 2
`define CSR_STALL_ACK 3
`define CSR_TX_READY 4
`define CSR_BANK1 6
`define CSR_TOGGLE 11
`define CSR_CNT_LO 16
`define MASK_RESET 14'h0200
`define MASK_ALWAYS 14'h1000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_KHZ 200000
`define SUSPEND_IDLE_MS 3
`define SUSPEND_IDLE_CYCLES (`SUSPEND_IDLE_MS * `CLK_KHZ)
`define IDLE_CNT_W 20

`endif

// >>> verilog/usb_flags_pkg.sv
// Types shared by the USB flag block modules
`include "usb_flags_defs.svh"

package usb_flags_pkg;

  typedef struct packed {
    logic tx_complete;
    logic bank0;
    logic setup;
    logic stall_ack;
    logic tx_ready;
    logic bank1;
    logic toggle;
    logic [`CNT_W-1:0] count;
  } ep_flags_t;

  typedef struct packed {
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
  } apb_state_t;

endpackage

// >>> verilog/reg_if.sv
// Register access carrier between the bus front end and the register owners
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

interface reg_if;
  logic wr;
  logic [`ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic err;

  modport bus_side (output wr, output addr, output wdata, input rdata, input err);
  modport reg_side (input wr, input addr, input wdata, output rdata, output err);
  modport watch (input wr, input addr, input wdata);
endinterface

// >>> verilog/apb_front.sv
// APB slave front end with one wait state
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

module apb_front (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Register side
  reg_if.bus_side regs
);

  usb_flags_pkg::apb_state_t st_reg;
  usb_flags_pkg::apb_state_t st_next;

  // Write lands on the very edge that samples pready high
  assign regs.wr = psel & penable & pwrite & st_reg.pready_reg;
  assign regs.addr = paddr;
  assign regs.wdata = pwdata;
  assign pready = st_reg.pready_reg;
  assign pslverr = st_reg.pslverr_reg;
  assign prdata = st_reg.prdata_reg;

  always_comb begin
    st_next = st_reg;
    st_next.pready_reg = 1'b0;
    st_next.pslverr_reg = 1'b0;
    if (psel && penable && !st_reg.pready_reg) begin
      st_next.pready_reg = 1'b1;
      st_next.pslverr_reg = regs.err;
      st_next.prdata_reg = pwrite ? 32'h0 : regs.rdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// >>> verilog/ep_flags.sv
// Per-endpoint control and status flags, byte count and data toggle
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

module ep_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register writes
  reg_if.watch regs,
  // USB side events, one bit per endpoint, and the shared receive byte count
  input wire logic [`NUM_EP-1:0] ev_setup,
  input wire logic [`NUM_EP-1:0] ev_bank0,
  input wire logic [`NUM_EP-1:0] ev_bank1,
  input wire logic [`NUM_EP-1:0] ev_tx_ack,
  input wire logic [`NUM_EP-1:0] ev_stall_ack,
  input wire logic [`NUM_EP-1:0] ev_tx_sent,
  input wire logic [`NUM_EP-1:0] ev_toggle,
  input wire logic [`CNT_W-1:0] rx_count,
  // Endpoint resets held by firmware
  input wire logic [`NUM_EP-1:0] ep_rst,
  // Results
  output logic [`NUM_EP-1:0] ep_any,
  output logic [`NUM_EP-1:0] tx_ready,
  output logic [`NUM_EP-1:0] toggle,
  output logic [`NUM_EP*32-1:0] csr_rd
);

  typedef struct packed {
    logic [`NUM_EP-1:0] setup;
    logic [`NUM_EP-1:0] bank0;
    logic [`NUM_EP-1:0] bank1;
    logic [`NUM_EP-1:0] tx_ack;
    logic [`NUM_EP-1:0] stall_ack;
    logic [`NUM_EP-1:0] tx_sent;
    logic [`NUM_EP-1:0] flip;
    logic [`CNT_W-1:0] count;
  } ev_t;

  typedef struct packed {
    ev_t ev;
    usb_flags_pkg::ep_flags_t [`NUM_EP-1:0] ep;
  } ep_state_t;

  ep_state_t st_reg;
  ep_state_t st_next;
  usb_flags_pkg::ep_flags_t ep_nx [`NUM_EP];

  genvar i;
  generate
    for (i = 0; i < `NUM_EP; i++) begin : g_ep
      logic wr_csr;
      logic [31:0] wd;
      usb_flags_pkg::ep_flags_t cur;
      assign cur = st_reg.ep[i];
      assign wd = regs.wdata;
      assign wr_csr = regs.wr &&
        regs.addr == `ADDR_W'(`OFS_EP_CSR_BASE + i * `OFS_EP_CSR_STEP);
      // Writing zero clears a hardware flag, a new event in the same cycle wins
      assign ep_nx[i].tx_complete = st_reg.ev.tx_ack[i] |
        (cur.tx_complete & ~(wr_csr & ~wd[`CSR_TX_COMPLETE]));
      assign ep_nx[i].bank0 = st_reg.ev.bank0[i] |
        (cur.bank0 & ~(wr_csr & ~wd[`CSR_BANK0]));
      assign ep_nx[i].setup = st_reg.ev.setup[i] |
        (cur.setup & ~(wr_csr & ~wd[`CSR_SETUP]));
      assign ep_nx[i].stall_ack = st_reg.ev.stall_ack[i] |
        (cur.stall_ack & ~(wr_csr & ~wd[`CSR_STALL_ACK]));
      assign ep_nx[i].bank1 = st_reg.ev.bank1[i] |
        (cur.bank1 & ~(wr_csr & ~wd[`CSR_BANK1]));
      // Firmware only sets, the device only clears once the packet is sent
      assign ep_nx[i].tx_ready = (cur.tx_ready & ~st_reg.ev.tx_sent[i]) |
        (wr_csr & wd[`CSR_TX_READY]);
      // Endpoint reset returns the toggle to DATA0 and empties the count
      assign ep_nx[i].toggle = ep_rst[i] ? 1'b0 : cur.toggle ^ st_reg.ev.flip[i];
      assign ep_nx[i].count = ep_rst[i] ? '0 :
        (st_reg.ev.bank0[i] | st_reg.ev.bank1[i]) ? st_reg.ev.count : cur.count;
      // Interrupt follows the flags, so only a flag clear can drop it
      assign ep_any[i] = cur.tx_complete | cur.bank0 | cur.bank1 |
        cur.setup | cur.stall_ack;
      assign tx_ready[i] = cur.tx_ready;
      assign toggle[i] = cur.toggle;
      assign csr_rd[i*32 +: 32] = {5'h0,
        (ep_rst[i] ? `CNT_W'(0) : cur.count),
        4'h0, cur.toggle, 4'h0, cur.bank1, 1'b0, cur.tx_ready,
        cur.stall_ack, cur.setup, cur.bank0, cur.tx_complete};
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    // One register stage between the USB event lines and the flags
    st_next.ev.setup = ev_setup;
    st_next.ev.bank0 = ev_bank0;
    st_next.ev.bank1 = ev_bank1;
    st_next.ev.tx_ack = ev_tx_ack;
    st_next.ev.stall_ack = ev_stall_ack;
    st_next.ev.tx_sent = ev_tx_sent;
    st_next.ev.flip = ev_toggle;
    st_next.ev.count = rx_count;
    for (int k = 0; k < `NUM_EP; k++) begin
      st_next.ep[k] = ep_nx[k];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// >>> verilog/usb_dev_flags.sv
// USB device interrupt status, clear, mask, endpoint reset and flag block with APB access
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

module usb_dev_flags #(
  parameter int IDLE_CYCLES = `SUSPEND_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  // Bus events from the USB port logic
  input wire logic BUS_ACTIVE,
  input wire logic RESUME_DET,
  input wire logic EXT_RESUME_DET,
  input wire logic FRAME_START_DET,
  input wire logic BUS_RESET_DET,
  input wire logic BUS_RESET_END,
  // Endpoint events from the USB port logic
  input wire logic [`NUM_EP-1:0] EP_SETUP_RX,
  input wire logic [`NUM_EP-1:0] EP_BANK0_RX,
  input wire logic [`NUM_EP-1:0] EP_BANK1_RX,
  input wire logic [`NUM_EP-1:0] EP_TX_ACK,
  input wire logic [`NUM_EP-1:0] EP_STALL_ACK,
  input wire logic [`NUM_EP-1:0] EP_TX_SENT,
  input wire logic [`NUM_EP-1:0] EP_TOGGLE_FLIP,
  input wire logic [`CNT_W-1:0] EP_RX_COUNT,
  // Outputs
  output logic IRQ,
  output logic SUSPENDED,
  output logic [`NUM_EP-1:0] EP_FIFO_CLR,
  output logic [`NUM_EP-1:0] EP_TX_READY,
  output logic [`NUM_EP-1:0] EP_DATA_TOGGLE
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`IRQ_W-1:`EVT_LO] events;
    logic [`IRQ_W-1:0] mask;
    logic [`NUM_EP-1:0] ep_rst;
    logic [`IDLE_CNT_W-1:0] idle_cnt;
    logic suspended;
    logic irq;
    logic active_q;
    logic resume_q;
    logic ext_resume_q;
    logic frame_q;
    logic reset_det_q;
    logic reset_end_q;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  reg_if regs ();

  logic [`NUM_EP-1:0] ep_any;
  logic [`NUM_EP*32-1:0] csr_rd;
  logic [`IRQ_W-1:0] status;
  logic [`IRQ_W-1:0] mask_eff;
  logic [`IRQ_W-1:0] clr;
  logic wr_clear;
  logic wr_mask;
  logic wr_rst;

  // ----------------------------------------------------------------
  // Bus front end and endpoint flags
  // ----------------------------------------------------------------
  apb_front u_apb (
    .clk(CLK),
    .rst_n(RSTN),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .prdata(PRDATA),
    .regs(regs.bus_side)
  );

  ep_flags u_ep (
    .clk(CLK),
    .rst_n(RSTN),
    .regs(regs.watch),
    .ev_setup(EP_SETUP_RX),
    .ev_bank0(EP_BANK0_RX),
    .ev_bank1(EP_BANK1_RX),
    .ev_tx_ack(EP_TX_ACK),
    .ev_stall_ack(EP_STALL_ACK),
    .ev_tx_sent(EP_TX_SENT),
    .ev_toggle(EP_TOGGLE_FLIP),
    .rx_count(EP_RX_COUNT),
    .ep_rst(st_reg.ep_rst),
    .ep_any(ep_any),
    .tx_ready(EP_TX_READY),
    .toggle(EP_DATA_TOGGLE),
    .csr_rd(csr_rd)
  );

  // ----------------------------------------------------------------
  // Status view and register decode
  // ----------------------------------------------------------------
  assign status = {st_reg.events, 2'b00, ep_any};
  // The bus reset end source cannot be masked off
  assign mask_eff = st_reg.mask | `MASK_ALWAYS;
  assign wr_clear = regs.wr && regs.addr == `OFS_IRQ_CLEAR;
  assign wr_mask = regs.wr && regs.addr == `OFS_IRQ_MASK;
  assign wr_rst = regs.wr && regs.addr == `OFS_EP_RESET;
  // Only the bus event bits are clearable here, endpoint bits ignore it
  assign clr = wr_clear ? (regs.wdata[`IRQ_W-1:0] & {{(`IRQ_W-`EVT_LO){1'b1}}, 8'h00}) :
    '0;

  always_comb begin
    regs.rdata = 32'h0;
    regs.err = 1'b1;
    unique case (regs.addr)
      `OFS_IRQ_MASK: begin
        regs.rdata = {18'h0, mask_eff};
        regs.err = 1'b0;
      end
      `OFS_IRQ_STATUS: begin
        regs.rdata = {18'h0, status};
        regs.err = 1'b0;
      end
      `OFS_IRQ_CLEAR: begin
        regs.err = 1'b0;
      end
      `OFS_EP_RESET: begin
        regs.rdata = {26'h0, st_reg.ep_rst};
        regs.err = 1'b0;
      end
      default: begin
        for (int k = 0; k < `NUM_EP; k++) begin
          if (regs.addr == `ADDR_W'(`OFS_EP_CSR_BASE + k * `OFS_EP_CSR_STEP)) begin
            regs.rdata = csr_rd[k*32 +: 32];
            regs.err = 1'b0;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Event lines are registered once before they touch the status bits
    st_next.active_q = BUS_ACTIVE;
    st_next.resume_q = RESUME_DET;
    st_next.ext_resume_q = EXT_RESUME_DET;
    st_next.frame_q = FRAME_START_DET;
    st_next.reset_det_q = BUS_RESET_DET;
    st_next.reset_end_q = BUS_RESET_END;

    // Clear first, then set, so an event in the clear cycle survives
    st_next.events = st_reg.events & ~clr[`IRQ_W-1:`EVT_LO];
    if (st_reg.resume_q) begin
      st_next.events[`BIT_RESUME] = 1'b1;
    end
    if (st_reg.ext_resume_q) begin
      st_next.events[`BIT_EXT_RESUME] = 1'b1;
    end
    if (st_reg.frame_q) begin
      st_next.events[`BIT_FRAME_START] = 1'b1;
    end
    if (st_reg.reset_end_q) begin
      st_next.events[`BIT_BUS_RESET_DONE] = 1'b1;
    end
    if (st_reg.resume_q || st_reg.reset_det_q) begin
      st_next.events[`BIT_WAKEUP] = 1'b1;
    end

    // Idle timer: saturates and flags suspend once per idle stretch
    if (st_reg.active_q) begin
      st_next.idle_cnt = '0;
      st_next.suspended = 1'b0;
    end else if (st_reg.idle_cnt != `IDLE_CNT_W'(IDLE_CYCLES - 1)) begin
      st_next.idle_cnt = st_reg.idle_cnt + `IDLE_CNT_W'(1);
    end else if (!st_reg.suspended) begin
      st_next.suspended = 1'b1;
      st_next.events[`BIT_SUSPEND] = 1'b1;
    end

    if (wr_mask) begin
      st_next.mask = regs.wdata[`IRQ_W-1:0];
    end
    // Held until firmware writes zero; flags in the endpoint are untouched
    if (wr_rst) begin
      st_next.ep_rst = regs.wdata[`NUM_EP-1:0];
    end

    st_next.irq = |(status & mask_eff);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.mask <= `MASK_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign IRQ = st_reg.irq;
  assign SUSPENDED = st_reg.suspended;
  assign EP_FIFO_CLR = st_reg.ep_rst;

endmodule

// >>> bench/usb_dev_flags_checker.sv
// Port-level assertion checker for the USB flag block
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

module usb_dev_flags_checker #(
  parameter int IDLE_CYCLES = `SUSPEND_IDLE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  // Port events
  input wire logic BUS_ACTIVE,
  input wire logic BUS_RESET_END,
  input wire logic [`NUM_EP-1:0] EP_TX_SENT,
  // Outputs
  input wire logic IRQ,
  input wire logic SUSPENDED,
  input wire logic [`NUM_EP-1:0] EP_FIFO_CLR,
  input wire logic [`NUM_EP-1:0] EP_TX_READY,
  input wire logic [`NUM_EP-1:0] EP_DATA_TOGGLE
);
  logic done;
  logic wr_csr;
  logic rst_wr;
  logic mask_wr_reg;
  logic [31:0] idle_reg;

  assign done = PSEL && PENABLE && PREADY;
  assign wr_csr = done && PWRITE && PADDR >= `OFS_EP_CSR_BASE;
  assign rst_wr = done && PWRITE && PADDR == `OFS_EP_RESET;

  // Idle run length as the port sees it, so suspend can be tied to its cause
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      idle_reg <= 32'h0;
      mask_wr_reg <= 1'b0;
    end else begin
      idle_reg <= BUS_ACTIVE ? 32'h0 : idle_reg + 32'h1;
      if (done && PWRITE && PADDR == `OFS_IRQ_MASK) begin
        mask_wr_reg <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  AST_APB_ONE_WAIT: assert property ($rose(PENABLE) && PSEL |-> ##1 PREADY ##1 !PREADY)
    else $error("APB answer not after one wait state");
  AST_CLEAR_READS_ZERO: assert property (done && !PWRITE && PADDR == `OFS_IRQ_CLEAR |-> PRDATA == 32'h0)
    else $error("Clear register read not zero");
  AST_MASK_RESET: assert property (done && !PWRITE && PADDR == `OFS_IRQ_MASK && !mask_wr_reg |-> PRDATA == 32'h1200)
    else $error("Mask reset value wrong");
  AST_BUS_RESET_IRQ: assert property (BUS_RESET_END |-> ##3 IRQ)
    else $error("Bus reset end did not raise IRQ");
  AST_TXRDY_SET: assert property (|(EP_TX_READY & ~$past(EP_TX_READY)) |-> $past(wr_csr) || $past(wr_csr, 2))
    else $error("Transmit ready rose without a write");
  AST_TXRDY_CLR: assert property (!(|($past(EP_TX_READY) & ~EP_TX_READY & ~$past(EP_TX_SENT) & ~$past(EP_TX_SENT, 2) & ~$past(EP_TX_SENT, 3))))
    else $error("Transmit ready fell without a sent packet");
  AST_EP_RESET_WRITE: assert property (rst_wr |=> EP_FIFO_CLR == $past(PWDATA[`NUM_EP-1:0]))
    else $error("Endpoint reset not taken from write");
  AST_EP_RESET_HOLD: assert property (!rst_wr |=> $stable(EP_FIFO_CLR))
    else $error("Endpoint reset changed on its own");
  AST_TOGGLE_HELD: assert property (!(|(EP_FIFO_CLR & $past(EP_FIFO_CLR) & $past(EP_FIFO_CLR, 2) & EP_DATA_TOGGLE)))
    else $error("Toggle not DATA0 under endpoint reset");
  AST_SUSPEND_IDLE: assert property ($rose(SUSPENDED) |-> idle_reg >= IDLE_CYCLES)
    else $error("Suspend before idle time");

  cover property ($rose(SUSPENDED));
  cover property ($rose(IRQ));
  cover property (|EP_FIFO_CLR);
endmodule

bind usb_dev_flags usb_dev_flags_checker #(.IDLE_CYCLES(IDLE_CYCLES)) u_checker (
  .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
  .BUS_ACTIVE(BUS_ACTIVE), .BUS_RESET_END(BUS_RESET_END), .EP_TX_SENT(EP_TX_SENT),
  .IRQ(IRQ), .SUSPENDED(SUSPENDED), .EP_FIFO_CLR(EP_FIFO_CLR),
  .EP_TX_READY(EP_TX_READY), .EP_DATA_TOGGLE(EP_DATA_TOGGLE)
);

// >>> bench/usb_port_model.sv
// Behavioural model of the USB port logic that feeds bus and endpoint events
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

module usb_port_model (
  // Clock and command
  input wire logic clk,
  input wire logic go,
  input wire logic [3:0] kind,
  input wire logic [2:0] ep,
  input wire logic [`CNT_W-1:0] cnt,
  input wire logic idle,
  // Events: resume, ext resume, frame start, reset det, reset end
  output logic bus_active,
  output logic [4:0] bus_ev,
  // Setup, bank0, bank1, tx ack, stall, tx sent, toggle
  output logic [6:0][`NUM_EP-1:0] ep_ev,
  output logic [`CNT_W-1:0] rx_count
);
  logic [`CNT_W-1:0] churn;

  initial begin
    bus_active = 1'b1;
    bus_ev = '0;
    ep_ev = '0;
    rx_count = '0;
    churn = '0;
  end

  // One-cycle pulses; the count is noise unless paired with an endpoint pulse
  always @(posedge clk) begin
    bus_ev <= '0;
    ep_ev <= '0;
    churn <= churn + 11'h1D3;
    rx_count <= ~churn;
    bus_active <= !idle;
    if (go && kind < 4'h5) begin
      bus_ev[kind] <= 1'b1;
    end
    if (go && kind >= 4'h5) begin
      ep_ev[kind - 4'h5][ep] <= 1'b1;
      rx_count <= cnt;
    end
  end
endmodule

// >>> bench/usb_dev_flags_tb_top.sv
// Self-checking testbench of the USB flag block
`timescale 1ns/1ps
`include "usb_flags_defs.svh"

module usb_dev_flags_tb_top;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, suspended;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, rerr;
  logic [5:0] fifo_clr, tx_ready, toggle;
  logic go, idle, bus_active;
  logic [3:0] kind;
  logic [2:0] ep;
  logic [10:0] cnt_in, rx_count;
  logic [4:0] bus_ev;
  logic [6:0][5:0] ep_ev;
  // Reference state
  logic [13:0] evt, mask;
  logic [6:0] flg [6];
  logic [10:0] cnt [6];
  logic [5:0] tog;
  int n_mismatch, total_checks, k, c;
  int fb [5] = '{2, 1, 6, 0, 3};

  usb_dev_flags #(.IDLE_CYCLES(20)) u_dut (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
    .BUS_ACTIVE(bus_active), .RESUME_DET(bus_ev[0]), .EXT_RESUME_DET(bus_ev[1]),
    .FRAME_START_DET(bus_ev[2]), .BUS_RESET_DET(bus_ev[3]), .BUS_RESET_END(bus_ev[4]),
    .EP_SETUP_RX(ep_ev[0]), .EP_BANK0_RX(ep_ev[1]), .EP_BANK1_RX(ep_ev[2]),
    .EP_TX_ACK(ep_ev[3]), .EP_STALL_ACK(ep_ev[4]), .EP_TX_SENT(ep_ev[5]),
    .EP_TOGGLE_FLIP(ep_ev[6]), .EP_RX_COUNT(rx_count), .IRQ(irq), .SUSPENDED(suspended),
    .EP_FIFO_CLR(fifo_clr), .EP_TX_READY(tx_ready), .EP_DATA_TOGGLE(toggle)
  );

  usb_port_model u_port (
    .clk(clk), .go(go), .kind(kind), .ep(ep), .cnt(cnt_in), .idle(idle),
    .bus_active(bus_active), .bus_ev(bus_ev), .ep_ev(ep_ev), .rx_count(rx_count)
  );

  always #2.5 clk = ~clk;

  function automatic logic [31:0] e_stat();
    logic [31:0] s;
    s = {18'h0, evt};
    for (int i = 0; i < 6; i++) s[i] = |(flg[i] & 7'h4F);
    return s;
  endfunction

  function automatic logic [31:0] e_csr(int i);
    return {5'h0, cnt[i], 4'h0, tog[i], 4'h0, flg[i]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ----
  // Bus and event drivers
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    rdata = prdata;
    rerr = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next setup never meets this release in one step
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    apb(1'b1, a, d);
    i = (a - 8'h10) >> 2;
    if (a == `OFS_IRQ_MASK) mask = d[13:0];
    if (a == `OFS_IRQ_CLEAR) evt = evt & ~(d[13:0] & 14'h3F00);
    if (a == `OFS_EP_RESET) for (int j = 0; j < 6; j++) if (d[j]) {cnt[j], tog[j]} = '0;
    if (a >= 8'h10 && a < 8'h28) flg[i] = (flg[i] & d[6:0] & 7'h4F) | ((flg[i] | d[6:0]) & 7'h10);
    repeat (3) @(posedge clk);
  endtask

  task automatic ev(input int t, input int e, input logic [10:0] n);
    kind <= 4'(t);
    ep <= 3'(e);
    cnt_in <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    if (t == 0) evt[9] = 1'b1;
    if (t == 0 || t == 3) evt[13] = 1'b1;
    if (t == 1 || t == 2 || t == 4) evt[t == 4 ? 12 : t + 9] = 1'b1;
    if (t >= 5 && t < 10) flg[e][fb[t - 5]] = 1'b1;
    if (t == 6 || t == 7) cnt[e] = n;
    if (t == 10) flg[e][4] = 1'b0;
    if (t == 11) tog[e] = ~tog[e];
  endtask

  task automatic irq_chk();
    chk({31'h0, irq}, {31'h0, |(e_stat() & {18'h0, mask | 14'h1000})});
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {clk, rstn, psel, penable, pwrite, go, idle, paddr, pwdata, kind, ep, cnt_in} = '0;
    {evt, tog, n_mismatch, total_checks} = '0;
    mask = 14'h0200;
    for (int i = 0; i < 6; i++) {flg[i], cnt[i]} = '0;
    void'($urandom(32'h205AAE5C));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`OFS_IRQ_MASK, 32'h1200);
    wr(`OFS_IRQ_CLEAR, 32'h3F00);
    rd(`OFS_IRQ_CLEAR, 32'h0);
    rd(`OFS_IRQ_STATUS, e_stat());
    for (k = 0; k < 5; k++) begin
      ev(k, 0, 11'h0);
      rd(`OFS_IRQ_STATUS, e_stat());
      irq_chk();
    end
    wr(`OFS_IRQ_CLEAR, 32'h0);
    rd(`OFS_IRQ_STATUS, e_stat());
    for (k = 8; k < 14; k++) begin
      wr(`OFS_IRQ_CLEAR, 32'h1 << k);
      rd(`OFS_IRQ_STATUS, e_stat());
    end
    ev(2, 0, 11'h0);
    for (k = 0; k < 4; k++) begin
      wr(`OFS_IRQ_MASK, $urandom & 32'h3FFF);
      irq_chk();
    end
    // Each endpoint: a random cause, sticky status, release, then an IN cycle
    for (int i = 0; i < 6; i++) begin
      ev(5 + $urandom % 5, i, 11'($urandom));
      rd(8'h10 + 8'(4 * i), e_csr(i));
      wr(`OFS_IRQ_CLEAR, 32'h3F);
      rd(`OFS_IRQ_STATUS, e_stat());
      wr(8'h10 + 8'(4 * i), 32'h10);
      rd(8'h10 + 8'(4 * i), e_csr(i));
      chk({26'h0, tx_ready}, 32'h1 << i);
      ev(10, i, 11'h0);
      rd(8'h10 + 8'(4 * i), e_csr(i));
    end
    ev(11, 2, 11'h0);
    ev(6, 2, 11'h5A5);
    wr(`OFS_EP_RESET, 32'h4);
    rd(8'h18, e_csr(2));
    chk({20'h0, fifo_clr, toggle}, {20'h0, 6'h4, tog});
    wr(`OFS_EP_RESET, 32'h0);
    rd(8'h18, e_csr(2));
    apb(1'b0, 8'h40, 32'h0);
    chk(rerr | rdata, 32'h1);
    idle <= 1'b1;
    repeat (40) @(posedge clk);
    evt[8] = 1'b1;
    chk({31'h0, suspended}, 32'h1);
    idle <= 1'b0;
    rd(`OFS_IRQ_STATUS, e_stat());
    chk({31'h0, suspended}, 32'h0);
    // Mid-run reset: everything, the mask included, returns to its reset value
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    {evt, tog} = '0;
    mask = 14'h0200;
    for (int i = 0; i < 6; i++) {flg[i], cnt[i]} = '0;
    @(posedge clk);
    rd(`OFS_IRQ_MASK, 32'h1200);
    rd(`OFS_IRQ_STATUS, e_stat());
    irq_chk();
    wrap_up();
  end
endmodule
